/* File: bench/eew_bus_props.sv */
// bus-side assertions for the two-wire link
module eew_bus_props (
  input wire logic clk,
  input wire logic sampleClk,
  input wire logic rst_n,
  input wire logic masterSdaOe,
  input wire logic slaveSdaOe,
  input wire logic sclLine,
  input wire logic sdaLine
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////
  // link-clock checks: slave drive against the clock line
  drive_low_a: assert property (
    @(posedge sampleClk) disable iff (!rst_n) $changed(slaveSdaOe) |-> !sclLine)
    else $error("slave data moved with clock high");
  ack_hold_a: assert property (
    @(posedge sampleClk) disable iff (!rst_n) slaveSdaOe && sclLine |=> slaveSdaOe || !sclLine)
    else $error("slave let go in clock high");
  no_fight_a: assert property (
    @(posedge sampleClk) disable iff (!rst_n) slaveSdaOe && sclLine |-> !masterSdaOe)
    else $error("both ends drive data");
  ////////////////////////////////////////////////////////////
  // user-clock checks; the bound covers a read byte of zeros
  ack_release_a: assert property (
    @(posedge clk) disable iff (!rst_n) $rose(slaveSdaOe) |-> ##[1:1000] !slaveSdaOe)
    else $error("slave held data too long");
  start_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n) sclLine && $fell(sdaLine) |-> !slaveSdaOe [*8])
    else $error("slave drove data at start");
  stop_quiet_a: assert property (
    @(posedge clk) disable iff (!rst_n) sclLine && $rose(sdaLine) |-> !slaveSdaOe [*8])
    else $error("slave drove data at stop");
  bus_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n) sclLine && $rose(sdaLine) |-> (sclLine && sdaLine) [*8])
    else $error("bus not idle after stop");
  scl_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_n) $rose(sclLine) |-> sclLine [*8])
    else $error("clock high phase too short");
endmodule

/* File: bench/test_eeprom_two_wire_slave_front_end.sv */
// self-checking bench: master and slave ends joined over the carrier
module test_eeprom_two_wire_slave_front_end;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0;
  logic sampleClk = 0;
  logic rst_n = 0;
  logic opValid = 0;
  logic opAck = 0;
  logic writeBusy = 0;
  logic [2:0] hwAddrPins = 3'h6; // asymmetric, a reversed order misses
  logic [7:0] opData = 8'h00;
  logic [7:0] readByte = 8'hA6; // held still, sampled on the faster sampleClk by the slave
  eew_pkg::eew_op_t opCode = eew_pkg::OP_START;
  logic opReady, rspValid, rspAck, addrEvt, rwSel, standby;
  logic [7:0] rspData;
  logic [eew_pkg::WADDR_W-1:0] wordAddr;
  logic [eew_pkg::PAGE_W-1:0] pageSel;
  logic [eew_pkg::BYTE_IN_PAGE_W-1:0] byteSel;
  int failures = 0;
  int checks_done = 0;
  int evtCnt = 0; // captured commands
  ////////////////////////////////////////////////////////////
  // clocks, unrelated in phase
  initial
    forever #50 clk = ~clk;
  initial
  begin
    #7;
    forever #6 sampleClk = ~sampleClk;
  end
  eew_bus_if eew_bus_if_inst ();
  eew_master eew_master_inst (.clk(clk), .rst_n(rst_n), .bus(eew_bus_if_inst.master), .opValid(opValid),
    .opReady(opReady), .opCode(opCode), .opData(opData), .opAck(opAck), .rspValid(rspValid),
    .rspData(rspData), .rspAck(rspAck));
  eew_slave eew_slave_inst (.clk(clk), .rst_n(rst_n), .sampleClk(sampleClk), .bus(eew_bus_if_inst.slave),
    .hwAddrPins(hwAddrPins), .writeBusy(writeBusy), .readByte(readByte), .addrEvt(addrEvt),
    .wordAddr(wordAddr), .pageSel(pageSel), .byteSel(byteSel), .rwSel(rwSel), .standby(standby));
  eew_bus_props eew_bus_props_inst (.clk(clk), .sampleClk(sampleClk), .rst_n(rst_n),
    .masterSdaOe(eew_bus_if_inst.masterSdaOe), .slaveSdaOe(eew_bus_if_inst.slaveSdaOe),
    .sclLine(eew_bus_if_inst.sclLine), .sdaLine(eew_bus_if_inst.sdaLine));
  // count command pulses
  always @(posedge clk)
    if (addrEvt === 1'b1)
      evtCnt <= evtCnt + 1;
  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [7:0] dev(input logic rw);
    return {eew_pkg::DEV_TYPE_ID, hwAddrPins, rw};
  endfunction
  // one master op, offered for one clock, then wait for idle
  task automatic op(input eew_pkg::eew_op_t c, input logic [7:0] d, input logic a);
    @(negedge clk);
    opCode = c;
    opData = d;
    opAck = a;
    opValid = 1;
    @(negedge clk);
    opValid = 0;
    for (int i = 0; i < 1000 && opReady !== 1'b1; i++)
      @(negedge clk);
    // a limit that runs out shows here as ready still low
    check("ready", opReady, 1);
    // byte ops pulse the response in the cycle the sequencer goes idle
    check("rsp", rspValid, (c == eew_pkg::OP_WRITE || c == eew_pkg::OP_READ));
  endtask
  task automatic wr(input logic [7:0] d, input logic ack);
    op(eew_pkg::OP_WRITE, d, 0);
    check("ack", rspAck, ack);
  endtask
  ////////////////////////////////////////////////////////////
  // address capture, repeated start, read with ack then nack
  task automatic t_addr;
    int n;
    n = evtCnt;
    check("standby", standby, 1);
    op(eew_pkg::OP_START, 0, 0);
    repeat (10) @(negedge clk);
    check("standby", standby, 0);
    wr(dev(0), 1);
    wr(8'hAB, 1);
    wr(8'hCD, 1);
    check("evt", evtCnt - n, 1);
    check("addr", wordAddr, 15'h2BCD);
    check("page", pageSel, 9'h0AF);
    check("byte", byteSel, 6'h0D);
    check("rw", rwSel, 0);
    wr(8'h3C, 1);
    op(eew_pkg::OP_START, 0, 0);
    wr(dev(1), 1);
    check("evt", evtCnt - n, 2);
    check("rw", rwSel, 1);
    op(eew_pkg::OP_READ, 0, 1);
    check("rd", rspData, readByte);
    op(eew_pkg::OP_READ, 0, 0);
    check("rd", rspData, readByte);
    repeat (10) @(negedge clk);
    check("standby", standby, 1);
    op(eew_pkg::OP_STOP, 0, 0);
  endtask
  // wrong type, swapped select order, busy write: all refused
  task automatic t_refuse;
    logic [7:0] bad [3];
    int n;
    bad = '{{4'h6, hwAddrPins, 1'b0}, {eew_pkg::DEV_TYPE_ID, 3'h3, 1'b0}, dev(0)};
    n = evtCnt;
    for (int i = 0; i < 3; i++)
    begin
      writeBusy = (i == 2);
      op(eew_pkg::OP_START, 0, 0);
      wr(bad[i], 0);
      wr(8'h00, 0);
      check("standby", standby, 1);
      op(eew_pkg::OP_STOP, 0, 0);
    end
    writeBusy = 0;
    check("evt", evtCnt - n, 0);
  endtask
  // interrupted command, recovery sequence, then a fresh command
  task automatic t_recover;
    hwAddrPins = 3'h1;
    op(eew_pkg::OP_START, 0, 0);
    wr(dev(0), 1);
    op(eew_pkg::OP_WRITE, 8'hFF, 0);
    op(eew_pkg::OP_START, 0, 0);
    op(eew_pkg::OP_STOP, 0, 0);
    repeat (10) @(negedge clk);
    check("standby", standby, 1);
    op(eew_pkg::OP_START, 0, 0);
    wr(dev(1), 1);
    check("rw", rwSel, 1);
    op(eew_pkg::OP_READ, 0, 0);
    check("rd", rspData, readByte);
    repeat (10) @(negedge clk);
    check("standby", standby, 1);
    op(eew_pkg::OP_STOP, 0, 0);
  endtask
  task automatic end_sim;
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1;
    t_addr();
    t_refuse();
    t_recover();
    end_sim();
  end
  // watchdog, well past the expected run of about two ms
  initial
  begin
    #5000000;
    failures++;
    end_sim();
  end
endmodule

/* File: hw/eew_master.sv */
// master end: clock divider and byte-level start, stop, write and read sequencer
module eew_master (
  input wire logic clk,
  input wire logic rst_n,
  eew_bus_if.master bus,
  input wire logic opValid,
  output logic opReady,
  input wire eew_pkg::eew_op_t opCode,
  input wire logic [7:0] opData,
  input wire logic opAck,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspAck
);
  //////////////////////////////////////////////////////////////////////////
  // state and quarter-period divider
  eew_pkg::eew_mst_t state_reg, state_next;
  logic [15:0] qCnt_reg, qCnt_next; // cycles within a quarter
  logic [1:0] phase_reg, phase_next; // quarter of the bit
  logic [3:0] bitIdx_reg, bitIdx_next; // bit of nine
  logic [7:0] data_reg, data_next; // shift out and in
  logic isRead_reg, isRead_next;
  logic ackTx_reg, ackTx_next; // acknowledge to send on read
  logic sclLow_reg, sclLow_next;
  logic sdaLow_reg, sdaLow_next;
  logic rspValid_reg, rspValid_next;
  logic [7:0] rspData_reg, rspData_next;
  logic rspAck_reg, rspAck_next;
  logic sdaA_reg; // first stage, read only by second
  logic sdaB_reg; // data line, synchronised
  logic tick;
  logic bitDrive;
  localparam logic [15:0] QLAST = 16'(eew_pkg::QUARTER_CYC - 1);
  assign tick = (qCnt_reg == QLAST);
  // release for the slave in the ninth bit of a write and during read data
  assign bitDrive = (bitIdx_reg < eew_pkg::BYTE_BITS) ? (!isRead_reg && !data_reg[7]) : (isRead_reg && ackTx_reg);
  assign opReady = (state_reg == eew_pkg::M_IDLE);

  // sequencer; bit data changes only in the first quarter while clock is low, start and stop move it with clock high
  always_comb
  begin
    state_next = state_reg;
    qCnt_next = tick ? 16'h0000 : qCnt_reg + 16'h0001;
    phase_next = phase_reg;
    bitIdx_next = bitIdx_reg;
    data_next = data_reg;
    isRead_next = isRead_reg;
    ackTx_next = ackTx_reg;
    sclLow_next = sclLow_reg;
    sdaLow_next = sdaLow_reg;
    rspValid_next = 1'b0;
    rspData_next = rspData_reg;
    rspAck_next = rspAck_reg;
    if (state_reg == eew_pkg::M_IDLE)
    begin
      qCnt_next = 16'h0000;
      phase_next = 2'h0;
      if (opValid)
      begin
        bitIdx_next = 4'h0;
        data_next = opData;
        isRead_next = (opCode == eew_pkg::OP_READ);
        ackTx_next = opAck;
        case (opCode)
          eew_pkg::OP_START: state_next = eew_pkg::M_START;
          eew_pkg::OP_STOP: state_next = eew_pkg::M_STOP;
          default: state_next = eew_pkg::M_BIT;
        endcase
      end
    end
    else if (tick)
    begin
      phase_next = phase_reg + 2'h1;
      case (state_reg)
        eew_pkg::M_START:
        begin
          // release data, raise clock, drop data, drop clock
          case (phase_reg)
            2'h0: sdaLow_next = 1'b0;
            2'h1: sclLow_next = 1'b0;
            2'h2: sdaLow_next = 1'b1;
            default:
            begin
              sclLow_next = 1'b1;
              state_next = eew_pkg::M_IDLE;
            end
          endcase
        end
        eew_pkg::M_STOP:
        begin
          // data low, raise clock, raise data: bus idle
          case (phase_reg)
            2'h0: sdaLow_next = 1'b1;
            2'h1: sclLow_next = 1'b0;
            2'h2: sdaLow_next = 1'b0;
            default: state_next = eew_pkg::M_IDLE;
          endcase
        end
        default:
        begin
          case (phase_reg)
            2'h0: sdaLow_next = bitDrive;
            2'h1: sclLow_next = 1'b0;
            2'h2:
            begin
              if (bitIdx_reg < eew_pkg::BYTE_BITS)
                data_next = {data_reg[6:0], sdaB_reg};
              else
                rspAck_next = !sdaB_reg;
            end
            default:
            begin
              sclLow_next = 1'b1;
              if (bitIdx_reg == eew_pkg::BYTE_BITS)
              begin
                state_next = eew_pkg::M_IDLE;
                rspValid_next = 1'b1;
                rspData_next = data_reg;
              end
              else
                bitIdx_next = bitIdx_reg + 4'h1;
            end
          endcase
        end
      endcase
    end
  end

  // registers; reset leaves both lines released so the bus is idle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= eew_pkg::M_IDLE;
      qCnt_reg <= 16'h0000;
      phase_reg <= 2'h0;
      bitIdx_reg <= 4'h0;
      data_reg <= 8'h00;
      isRead_reg <= 1'b0;
      ackTx_reg <= 1'b0;
      sclLow_reg <= 1'b0;
      sdaLow_reg <= 1'b0;
      rspValid_reg <= 1'b0;
      rspData_reg <= 8'h00;
      rspAck_reg <= 1'b0;
      sdaA_reg <= 1'b1;
      sdaB_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      qCnt_reg <= qCnt_next;
      phase_reg <= phase_next;
      bitIdx_reg <= bitIdx_next;
      data_reg <= data_next;
      isRead_reg <= isRead_next;
      ackTx_reg <= ackTx_next;
      sclLow_reg <= sclLow_next;
      sdaLow_reg <= sdaLow_next;
      rspValid_reg <= rspValid_next;
      rspData_reg <= rspData_next;
      rspAck_reg <= rspAck_next;
      sdaA_reg <= bus.sdaLine;
      sdaB_reg <= sdaA_reg;
    end
  end

  // open-drain drives
  assign bus.masterSclO = 1'b0;
  assign bus.masterSclOe = sclLow_reg;
  assign bus.masterSdaO = 1'b0;
  assign bus.masterSdaOe = sdaLow_reg;
  assign rspValid = rspValid_reg;
  assign rspData = rspData_reg;
  assign rspAck = rspAck_reg;
endmodule

/* File: hw/eew_slave.sv */
// slave end: start/stop detection, address decode and word address capture
module eew_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sampleClk,
  eew_bus_if.slave bus,
  input wire logic [2:0] hwAddrPins,
  input wire logic writeBusy,
  input wire logic [7:0] readByte,
  output logic addrEvt,
  output logic [eew_pkg::WADDR_W-1:0] wordAddr,
  output logic [eew_pkg::PAGE_W-1:0] pageSel,
  output logic [eew_pkg::BYTE_IN_PAGE_W-1:0] byteSel,
  output logic rwSel,
  output logic standby
);
  //////////////////////////////////////////////////////////////////////////
  // line synchronisers and glitch filters, sampling clock domain
  logic [1:0] lineRaw; // index 1 clock, index 0 data
  logic [1:0] filtLine; // filtered line levels
  assign lineRaw = {bus.sclLine, bus.sdaLine};

  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gLine
      logic syncA_reg; // first stage, read only by second
      logic syncB_reg; // second stage
      logic [eew_pkg::FILT_LEN-1:0] hist_reg; // recent samples
      logic filt_reg; // settled level
      // two flops, then a level only moves when all samples agree
      always_ff @(posedge sampleClk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          syncA_reg <= 1'b1;
          syncB_reg <= 1'b1;
          hist_reg <= '1;
          filt_reg <= 1'b1;
        end
        else
        begin
          syncA_reg <= lineRaw[g];
          syncB_reg <= syncA_reg;
          hist_reg <= {hist_reg[eew_pkg::FILT_LEN-2:0], syncB_reg};
          if (&hist_reg)
            filt_reg <= 1'b1;
          else if (~|hist_reg)
            filt_reg <= 1'b0;
        end
      end
      assign filtLine[g] = filt_reg;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // edge and condition detection
  logic sclF; // filtered clock
  logic sdaF; // filtered data
  logic sclPrev_reg; // clock one sample ago
  logic sdaPrev_reg; // data one sample ago
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  assign sclF = filtLine[1];
  assign sdaF = filtLine[0];
  assign sclRise = sclF && !sclPrev_reg;
  assign sclFall = !sclF && sclPrev_reg;
  // data moving while clock stays high marks a start or a stop
  assign startDet = sclF && sclPrev_reg && sdaPrev_reg && !sdaF;
  assign stopDet = sclF && sclPrev_reg && !sdaPrev_reg && sdaF;

  // previous-sample registers
  always_ff @(posedge sampleClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end
    else
    begin
      sclPrev_reg <= sclF;
      sdaPrev_reg <= sdaF;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // inputs from the pins and the clk domain
  logic [2:0] hwA_reg; // first stage
  logic [2:0] hwB_reg; // select pins, synchronised
  logic busyA_reg;
  logic busyB_reg; // write busy, synchronised
  logic [7:0] rdA_reg;
  logic [7:0] rdB_reg; // read byte; caller keeps it static while a byte is sent

  // two-flop crossing of levels into the sampling clock
  always_ff @(posedge sampleClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hwA_reg <= 3'h0;
      hwB_reg <= 3'h0;
      busyA_reg <= 1'b0;
      busyB_reg <= 1'b0;
      rdA_reg <= 8'hFF;
      rdB_reg <= 8'hFF;
    end
    else
    begin
      hwA_reg <= hwAddrPins;
      hwB_reg <= hwA_reg;
      busyA_reg <= writeBusy;
      busyB_reg <= busyA_reg;
      rdA_reg <= readByte;
      rdB_reg <= rdA_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // link state machine
  eew_pkg::eew_dst_t state_reg, state_next;
  eew_pkg::eew_kind_t kind_reg, kind_next;
  logic [3:0] bitCnt_reg, bitCnt_next; // bits seen in this byte
  logic [7:0] shift_reg, shift_next; // received byte
  logic [7:0] tx_reg, tx_next; // byte being sent
  logic drvLow_reg, drvLow_next; // pulling data low
  logic [eew_pkg::WADDR_W-1:0] addr_reg, addr_next; // array pointer
  logic rw_reg, rw_next; // direction of this command
  logic evtTgl_reg, evtTgl_next; // flips per captured command
  logic stby_reg; // standby level for the crossing
  logic byteFull;
  logic devMatch;
  logic typeOk;
  logic selOk;
  assign byteFull = (bitCnt_reg == eew_pkg::BYTE_BITS);
  assign typeOk = (shift_reg[7:4] == eew_pkg::DEV_TYPE_ID);
  assign selOk = (shift_reg[3:1] == hwB_reg);
  // busy internal write hides the device from the bus
  assign devMatch = typeOk && selOk && !busyB_reg;

  // next-state logic; start wins over everything so a recovery always resyncs
  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    bitCnt_next = bitCnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    drvLow_next = drvLow_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    evtTgl_next = evtTgl_reg;
    if (startDet)
    begin
      // fresh or repeated start: expect a device address byte
      state_next = eew_pkg::ST_RECV;
      kind_next = eew_pkg::KD_DEV;
      bitCnt_next = 4'h0;
      drvLow_next = 1'b0;
    end
    else if (stopDet)
    begin
      state_next = eew_pkg::ST_STANDBY;
      drvLow_next = 1'b0;
    end
    else
    begin
      case (state_reg)
        eew_pkg::ST_STANDBY:
        begin
          drvLow_next = 1'b0;
        end
        eew_pkg::ST_RECV:
        begin
          if (sclRise && !byteFull)
          begin
            // msb first, one bit per rising clock
            shift_next = {shift_reg[6:0], sdaF};
            bitCnt_next = bitCnt_reg + 4'h1;
          end
          else if (sclFall && byteFull)
          begin
            // eighth fall: decide acknowledge
            if (kind_reg == eew_pkg::KD_DEV && !devMatch)
              state_next = eew_pkg::ST_STANDBY;
            else
            begin
              state_next = eew_pkg::ST_ACK;
              drvLow_next = 1'b1;
            end
            if (kind_reg == eew_pkg::KD_DEV && devMatch)
            begin
              rw_next = shift_reg[0];
              if (shift_reg[0])
                evtTgl_next = !evtTgl_reg;
            end
            else if (kind_reg == eew_pkg::KD_HI)
              addr_next[eew_pkg::HI_ADDR_MSB:eew_pkg::HI_ADDR_LSB] = shift_reg[6:0];
            else if (kind_reg == eew_pkg::KD_LO)
            begin
              addr_next[7:0] = shift_reg;
              evtTgl_next = !evtTgl_reg;
            end
          end
        end
        eew_pkg::ST_ACK:
        begin
          if (sclFall)
          begin
            // end of ninth clock: let go of data
            drvLow_next = 1'b0;
            bitCnt_next = 4'h0;
            if (kind_reg == eew_pkg::KD_DEV && rw_reg)
            begin
              state_next = eew_pkg::ST_SEND;
              tx_next = rdB_reg;
              drvLow_next = !rdB_reg[7];
            end
            else
            begin
              state_next = eew_pkg::ST_RECV;
              case (kind_reg)
                eew_pkg::KD_DEV: kind_next = eew_pkg::KD_HI;
                eew_pkg::KD_HI: kind_next = eew_pkg::KD_LO;
                default: kind_next = eew_pkg::KD_DATA; // data bytes acked, not stored
              endcase
            end
          end
        end
        eew_pkg::ST_SEND:
        begin
          if (sclRise)
            bitCnt_next = bitCnt_reg + 4'h1;
          else if (sclFall && byteFull)
          begin
            drvLow_next = 1'b0;
            state_next = eew_pkg::ST_ACKIN;
          end
          else if (sclFall)
          begin
            tx_next = {tx_reg[6:0], 1'b1};
            drvLow_next = !tx_reg[6];
          end
        end
        eew_pkg::ST_ACKIN:
        begin
          // high in the ninth clock ends the read
          if (sclRise)
            state_next = sdaF ? eew_pkg::ST_STANDBY : eew_pkg::ST_RESUME;
        end
        eew_pkg::ST_RESUME:
        begin
          if (sclFall)
          begin
            state_next = eew_pkg::ST_SEND;
            bitCnt_next = 4'h0;
            tx_next = rdB_reg;
            drvLow_next = !rdB_reg[7];
          end
        end
        default:
        begin
          state_next = eew_pkg::ST_STANDBY;
          drvLow_next = 1'b0;
        end
      endcase
    end
  end

  // link state registers; reset lands in standby with data released
  always_ff @(posedge sampleClk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= eew_pkg::ST_STANDBY;
      kind_reg <= eew_pkg::KD_DEV;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'hFF;
      drvLow_reg <= 1'b0;
      addr_reg <= '0;
      rw_reg <= 1'b0;
      evtTgl_reg <= 1'b0;
      stby_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      drvLow_reg <= drvLow_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      evtTgl_reg <= evtTgl_next;
      stby_reg <= (state_next == eew_pkg::ST_STANDBY);
    end
  end

  // open drain: only ever pull low
  assign bus.slaveSdaO = 1'b0;
  assign bus.slaveSdaOe = drvLow_reg;

  //////////////////////////////////////////////////////////////////////////
  // crossing back to clk; address is stable for many serial clocks after a flip
  logic tglA_reg;
  logic tglB_reg;
  logic tglC_reg;
  logic stbyA_reg;
  logic stbyB_reg;
  logic evtEdge;
  logic addrEvt_reg;
  logic [eew_pkg::WADDR_W-1:0] wordAddr_reg;
  logic rwSel_reg;
  assign evtEdge = tglB_reg ^ tglC_reg;

  // toggle synchroniser and output capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tglA_reg <= 1'b0;
      tglB_reg <= 1'b0;
      tglC_reg <= 1'b0;
      stbyA_reg <= 1'b1;
      stbyB_reg <= 1'b1;
      addrEvt_reg <= 1'b0;
      wordAddr_reg <= '0;
      rwSel_reg <= 1'b0;
    end
    else
    begin
      tglA_reg <= evtTgl_reg;
      tglB_reg <= tglA_reg;
      tglC_reg <= tglB_reg;
      stbyA_reg <= stby_reg;
      stbyB_reg <= stbyA_reg;
      addrEvt_reg <= evtEdge;
      if (evtEdge)
      begin
        wordAddr_reg <= addr_reg;
        rwSel_reg <= rw_reg;
      end
    end
  end

  // page and offset split of the pointer
  assign addrEvt = addrEvt_reg;
  assign wordAddr = wordAddr_reg;
  assign pageSel = wordAddr_reg[eew_pkg::WADDR_W-1:eew_pkg::BYTE_IN_PAGE_W];
  assign byteSel = wordAddr_reg[eew_pkg::BYTE_IN_PAGE_W-1:0];
  assign rwSel = rwSel_reg;
  assign standby = stbyB_reg;
endmodule

/* File: pkg/eew_bus_if.sv */
// two-wire bus carrier joining the master and the slave ends
interface eew_bus_if;
  logic masterSclO; // master clock drive value
  logic masterSclOe; // master pulls clock low
  logic masterSdaO; // master data drive value
  logic masterSdaOe; // master pulls data low
  logic slaveSdaO; // slave data drive value
  logic slaveSdaOe; // slave pulls data low
  logic sclLine; // resolved clock wire
  logic sdaLine; // resolved data wire
  // open-drain wired-and with pull-ups
  assign sclLine = !(masterSclOe && !masterSclO);
  assign sdaLine = !(masterSdaOe && !masterSdaO) && !(slaveSdaOe && !slaveSdaO);
  modport master (
    output masterSclO,
    output masterSclOe,
    output masterSdaO,
    output masterSdaOe,
    input sclLine,
    input sdaLine
  );
  modport slave (
    output slaveSdaO,
    output slaveSdaOe,
    input sclLine,
    input sdaLine
  );
endinterface

/* File: pkg/eew_pkg.sv */
// shared constants and types for the two-wire serial memory front end
package eew_pkg;
  // device type identifier; the value here is arbitrary
  localparam logic [3:0] DEV_TYPE_ID = 4'h5;
  // address field layout
  localparam int WADDR_W = 15;
  localparam int PAGE_W = 9;
  localparam int BYTE_IN_PAGE_W = 6;
  localparam int HI_ADDR_MSB = 14;
  localparam int HI_ADDR_LSB = 8;
  // bits per byte before the acknowledge clock
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // master clock and serial clock timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_NS = SCL_PERIOD_NS / 4;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // glitch filter depth on the sampling clock
  localparam int FILT_LEN = 3;
  // master byte-level commands
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_STOP = 2'b01,
    OP_WRITE = 2'b10,
    OP_READ = 2'b11
  } eew_op_t;
  // slave link states
  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK = 3'b010,
    ST_SEND = 3'b011,
    ST_ACKIN = 3'b100,
    ST_RESUME = 3'b101
  } eew_dst_t;
  // which byte of the command is being received
  typedef enum logic [1:0] {
    KD_DEV = 2'b00,
    KD_HI = 2'b01,
    KD_LO = 2'b10,
    KD_DATA = 2'b11
  } eew_kind_t;
  // master sequencer states
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_START = 2'b01,
    M_STOP = 2'b10,
    M_BIT = 2'b11
  } eew_mst_t;
endpackage
